//--- ssw_map.svh
// Timing constants for the supply supervisor and watchdog
`ifndef SSW_MAP_SVH
`define SSW_MAP_SVH
`define SSW_CLK_MHZ 100
// Times in their own units
`define SSW_HOLD_MS 200
`define SSW_HOLD_MIN_MS 130
`define SSW_HOLD_MAX_MS 270
`define SSW_WDOG_MS 1600
`define SSW_PROG_MS 10
`define SSW_GLITCH_NS 100
`define SSW_TRIP_US 5
// Derived cycle counts
`define SSW_HOLD_CYC (`SSW_HOLD_MS * 1000 * `SSW_CLK_MHZ)
`define SSW_WDOG_CYC (`SSW_WDOG_MS * 1000 * `SSW_CLK_MHZ)
`define SSW_PROG_CYC (`SSW_PROG_MS * 1000 * `SSW_CLK_MHZ)
`define SSW_GLITCH_CYC ((`SSW_GLITCH_NS * `SSW_CLK_MHZ + 999) / 1000)
`define SSW_TRIP_CYC (`SSW_TRIP_US * `SSW_CLK_MHZ)
`endif

//--- ssw_pkg.sv
// Types for the supply supervisor and watchdog
`default_nettype none
package ssw_pkg;
	typedef logic [31:0] ssw_cnt_t;
	typedef enum logic [1:0] {
		SSW_TRIP = 2'b00,
		SSW_HOLD = 2'b01,
		SSW_RUN = 2'b10
	} ssw_mode_e;
	typedef struct packed {
		logic [1:0] trip_sync;
		logic [1:0] wdi_sync;
		logic [1:0] rsth_sync;
		logic [1:0] rstl_sync;
		logic [1:0] wlock_sync;
		logic wdi_last;
		logic rsth_last;
		logic rstl_last;
		logic [3:0] rsth_flt;
		logic [3:0] rstl_flt;
		ssw_mode_e mode;
		ssw_cnt_t hold_cnt;
		ssw_cnt_t wdog_cnt;
		ssw_cnt_t prog_cnt;
		logic prog_busy;
	} ssw_state_s;
	typedef struct packed {
		logic rst_hi_oe_n;
		logic rst_lo_oe_n;
		logic bus_enable;
		logic write_allow;
	} ssw_out_s;
endpackage
`default_nettype wire

//--- ssw_top.sv
// Supply supervisor, reset conditioner, watchdog and write gate
// Function
// - Watchdog timeout when kick input has no edge for 1.6 s.
// - Hold resets during supply trip, then for about 200 ms after.
// - After hold, stop driving both open-drain reset outputs.
// - Supply trip asserts both reset outputs at once.
// - Reset asserts within 5 us of the trip indication.
// - Rising edge on active-high reset pin restarts the hold.
// - Falling edge on active-low reset pin restarts the hold.
// - External reset level makes device enter and drive reset itself.
// - Pulses on reset pins up to 100 ns are ignored.
// - Programming cycle starts at write stop, ends within 10 ms.
// - During programming the bus interface is disabled.
// - Write-lock high refuses every programming attempt.
// - Write-lock low or floating permits writes.
// - Any kick input edge clears the watchdog counter.
// - Watchdog counter stays cleared while reset is asserted.
// - Watchdog timeout puts both resets into reset.
// - While reset is active, memory access is refused.
`include "ssw_map.svh"
`default_nettype none
module ssw_top #(
	parameter ssw_pkg::ssw_cnt_t HOLD_CYC = `SSW_HOLD_CYC,
	parameter ssw_pkg::ssw_cnt_t WDOG_CYC = `SSW_WDOG_CYC,
	parameter ssw_pkg::ssw_cnt_t PROG_CYC = `SSW_PROG_CYC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// Supply trip indication, high while supply below level
	input wire logic supply_trip,
	// Watchdog kick input
	input wire logic watchdog_kick_input,
	// Active-high reset pin
	input wire logic rst_hi_in,
	output logic rst_hi_out,
	output logic rst_hi_oe_n,
	// Active-low reset pin
	input wire logic rst_lo_in_n,
	output logic rst_lo_out_n,
	output logic rst_lo_oe_n,
	// Write-lock pin
	input wire logic write_lock,
	// Memory side
	input wire logic write_stop,
	output logic bus_enable,
	output logic write_allow,
	output logic prog_busy,
	output logic reset_active
);
	localparam logic [3:0] GLITCH_CYC = 4'(`SSW_GLITCH_CYC);
	ssw_pkg::ssw_state_s st_reg, st_next;
	ssw_pkg::ssw_out_s out_reg, out_next;
	logic trip, kick_edge, hi_req, lo_req, in_reset;
	logic hi_fl, lo_fl, wdog_to;

	// Derived terms from synchronised inputs
	always_comb begin
		trip = st_reg.trip_sync[1];
		kick_edge = st_reg.wdi_sync[1] ^ st_reg.wdi_last;
		// A level must outlast the reject width, not merely reach it
		hi_fl = st_reg.rsth_flt > GLITCH_CYC;
		lo_fl = st_reg.rstl_flt > GLITCH_CYC;
		hi_req = hi_fl & ~st_reg.rsth_last;
		lo_req = lo_fl & ~st_reg.rstl_last;
		in_reset = st_reg.mode != ssw_pkg::SSW_RUN;
		wdog_to = st_reg.wdog_cnt >= WDOG_CYC - 32'd1;
	end

	// Next state
	always_comb begin
		st_next = st_reg;
		st_next.trip_sync = {st_reg.trip_sync[0], supply_trip};
		st_next.wdi_sync = {st_reg.wdi_sync[0], watchdog_kick_input};
		// Our own drive reads back as a reset level, so the pins
		// are sensed only while released, starting from a clean sync
		if (out_reg.rst_hi_oe_n) begin
			st_next.rsth_sync = {st_reg.rsth_sync[0], rst_hi_in};
			st_next.rstl_sync = {st_reg.rstl_sync[0], ~rst_lo_in_n};
		end else begin
			st_next.rsth_sync = 2'h0;
			st_next.rstl_sync = 2'h0;
		end
		st_next.wlock_sync = {st_reg.wlock_sync[0], write_lock};
		st_next.wdi_last = st_reg.wdi_sync[1];
		// Glitch filters: level must persist past the reject width
		if (!st_reg.rsth_sync[1])
			st_next.rsth_flt = 4'h0;
		else if (!hi_fl)
			st_next.rsth_flt = st_reg.rsth_flt + 4'h1;
		if (!st_reg.rstl_sync[1])
			st_next.rstl_flt = 4'h0;
		else if (!lo_fl)
			st_next.rstl_flt = st_reg.rstl_flt + 4'h1;
		st_next.rsth_last = hi_fl;
		st_next.rstl_last = lo_fl;
		// Reset state machine
		unique case (st_reg.mode)
			ssw_pkg::SSW_TRIP: begin
				st_next.hold_cnt = 32'h0;
				if (!trip)
					st_next.mode = ssw_pkg::SSW_HOLD;
			end
			ssw_pkg::SSW_HOLD: begin
				if (hi_req | lo_req | hi_fl | lo_fl)
					st_next.hold_cnt = 32'h0;
				else if (st_reg.hold_cnt >= HOLD_CYC - 32'd1)
					st_next.mode = ssw_pkg::SSW_RUN;
				else
					st_next.hold_cnt = st_reg.hold_cnt + 32'h1;
			end
			ssw_pkg::SSW_RUN: begin
				if (hi_req | lo_req | wdog_to) begin
					st_next.mode = ssw_pkg::SSW_HOLD;
					st_next.hold_cnt = 32'h0;
				end
			end
			default: st_next.mode = ssw_pkg::SSW_TRIP;
		endcase
		if (trip) begin
			st_next.mode = ssw_pkg::SSW_TRIP;
			st_next.hold_cnt = 32'h0;
		end
		// Watchdog counter
		if (in_reset || kick_edge || st_next.mode != ssw_pkg::SSW_RUN)
			st_next.wdog_cnt = 32'h0;
		else
			st_next.wdog_cnt = st_reg.wdog_cnt + 32'h1;
		// Programming cycle timer
		if (st_reg.prog_busy) begin
			if (st_reg.prog_cnt >= PROG_CYC - 32'd1) begin
				st_next.prog_busy = 1'b0;
				st_next.prog_cnt = 32'h0;
			end else
				st_next.prog_cnt = st_reg.prog_cnt + 32'h1;
		end else if (write_stop && !in_reset && !st_reg.wlock_sync[1]) begin
			st_next.prog_busy = 1'b1;
			st_next.prog_cnt = 32'h0;
		end
	end

	// Output decode, one reset state drives both pins
	always_comb begin
		out_next.rst_hi_oe_n = st_next.mode == ssw_pkg::SSW_RUN;
		out_next.rst_lo_oe_n = st_next.mode == ssw_pkg::SSW_RUN;
		out_next.bus_enable = st_next.mode == ssw_pkg::SSW_RUN
			&& !st_next.prog_busy;
		out_next.write_allow = out_next.bus_enable
			&& !st_next.wlock_sync[1];
	end

	// State registers
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '{trip_sync: 2'h3, mode: ssw_pkg::SSW_TRIP,
				default: '0};
			out_reg <= '{rst_hi_oe_n: 1'b0, rst_lo_oe_n: 1'b0,
				default: '0};
		end else begin
			st_reg <= st_next;
			out_reg <= out_next;
		end
	end

	assign rst_hi_oe_n = out_reg.rst_hi_oe_n;
	assign rst_lo_oe_n = out_reg.rst_lo_oe_n;
	assign rst_hi_out = 1'b1; // Active high level when driven
	assign rst_lo_out_n = 1'b0; // Active low level when driven
	assign bus_enable = out_reg.bus_enable;
	assign write_allow = out_reg.write_allow;
	assign prog_busy = st_reg.prog_busy;
	assign reset_active = ~out_reg.rst_hi_oe_n;

	// Checks
	a_trip_asserts: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		supply_trip |-> ##[1:4] !rst_hi_oe_n)
		else $error("reset not asserted after trip");
	a_pins_pair: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		rst_hi_oe_n == rst_lo_oe_n)
		else $error("reset pins disagree");
	a_reset_no_bus: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		!rst_hi_oe_n |-> !bus_enable)
		else $error("bus enabled during reset");
	a_prog_no_bus: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		prog_busy |-> !bus_enable)
		else $error("bus enabled while programming");
	a_lock_no_write: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		st_reg.wlock_sync[1] |-> !write_allow)
		else $error("write allowed while locked");
	a_wdog_cleared: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		in_reset |=> st_reg.wdog_cnt == 32'h0)
		else $error("watchdog counted in reset");
	a_kick_clears: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		kick_edge |=> st_reg.wdog_cnt == 32'h0)
		else $error("kick did not clear watchdog");
	a_wdog_resets: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		(wdog_to && !in_reset) |=> !rst_hi_oe_n)
		else $error("timeout gave no reset");
	a_glitch_ignored: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		!st_reg.rsth_sync[1] |=> !hi_fl)
		else $error("short pulse accepted");
	a_glitch_width: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		$rose(hi_fl) |-> $past(st_reg.rsth_sync[1], 11))
		else $error("reset pulse accepted too soon");
	a_prog_bounded: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		st_reg.prog_cnt <= PROG_CYC)
		else $error("programming overran");
	a_release_hold: assert property (
		@(posedge clk_sys) disable iff (!arst_n)
		$rose(rst_hi_oe_n) |-> $past(st_reg.hold_cnt) >= HOLD_CYC - 32'h1)
		else $error("reset released before full hold");
	// Main scenarios reached
	c_release: cover property (@(posedge clk_sys) $rose(rst_hi_oe_n));
	c_trip: cover property (@(posedge clk_sys) trip && $fell(rst_hi_oe_n));
	c_wdog_fire: cover property (@(posedge clk_sys) wdog_to && !in_reset);
	c_manual: cover property (@(posedge clk_sys) hi_req || lo_req);
	c_prog: cover property (@(posedge clk_sys) $fell(prog_busy));
endmodule
`default_nettype wire

//--- ssw_host.sv
// Host model that keeps the watchdog kicked
`default_nettype none
module ssw_host #(
	parameter int KICK_CYC = 60
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// Kick control and line
	input wire logic kick_en,
	output var logic kick
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt;
	// Toggle the kick line well inside the watchdog period
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cnt <= 0;
			kick <= 1'b0;
		end else if (kick_en && cnt == KICK_CYC - 1) begin
			cnt <= 0;
			kick <= ~kick;
		end else begin
			cnt <= kick_en ? cnt + 1 : 0;
		end
	end
endmodule
`default_nettype wire

//--- testbench.sv
// Bench for the supply supervisor and watchdog
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic lock;
		logic busy;
	} ssw_row_s;
	localparam int PROG = 20;
	localparam int WDOG = 200;
	logic clk_sys, arst_n, supply_trip, kick_en, kick, ext_hi, ext_lo_n;
	logic write_lock, write_stop, hi_out, hi_oe_n, lo_out_n, lo_oe_n;
	logic bus_enable, write_allow, prog_busy, reset_active;
	int fails = 0;
	int comparisons = 0;
	ssw_row_s rows [3] = '{'{1'b0, 1'b1}, '{1'b1, 1'b0}, '{1'b0, 1'b1}};
	// Open-drain pins with pull-down and pull-up
	wire hi_pin = hi_oe_n ? ext_hi : hi_out;
	wire lo_pin = lo_oe_n ? ext_lo_n : lo_out_n;
	ssw_top #(.HOLD_CYC(50), .WDOG_CYC(WDOG), .PROG_CYC(PROG)) ssw_top_i (
		.clk_sys, .arst_n, .supply_trip, .watchdog_kick_input(kick),
		.rst_hi_in(hi_pin), .rst_hi_out(hi_out), .rst_hi_oe_n(hi_oe_n),
		.rst_lo_in_n(lo_pin), .rst_lo_out_n(lo_out_n), .rst_lo_oe_n(lo_oe_n),
		.write_lock, .write_stop, .bus_enable, .write_allow, .prog_busy,
		.reset_active);
	ssw_host ssw_host_i (.clk_sys, .arst_n, .kick_en, .kick);
	// Clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic cyc(input int n);
		repeat (n) begin
			@(posedge clk_sys);
			#1;
		end
	endtask
	task automatic chk(input logic got, input logic exp, input string m);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: %s", $time, m);
		end
	endtask
	// Reset state is still unchanged after lo cycles, then reaches v within hi
	task automatic oe(input logic v, input int lo, input int hi);
		int n;
		n = 0;
		cyc(lo);
		if (lo > 0)
			chk(hi_oe_n, ~v, "reset state changed early");
		while (hi_oe_n !== v && n < hi) begin
			cyc(1);
			n++;
		end
		chk(lo_oe_n, hi_oe_n, "pins disagree");
		chk(hi_pin, ~v, "high pin level");
		chk(lo_pin, v, "low pin level");
		chk(reset_active, ~v, "reset flag");
	endtask
	task automatic pulse;
		write_stop = 1'b1;
		cyc(1);
		write_stop = 1'b0;
	endtask
	task automatic stop_test;
		$display("Counts: %0d comparisons, %0d fails", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Cut a hung run short
	initial begin
		#100us;
		fails++;
		stop_test();
	end
	// Main sequence
	initial begin
		arst_n = 1'b0;
		supply_trip = 1'b1;
		kick_en = 1'b0;
		ext_hi = 1'b0;
		ext_lo_n = 1'b1;
		write_lock = 1'b0;
		write_stop = 1'b0;
		cyc(8);
		arst_n = 1'b1;
		cyc(20);
		chk(hi_oe_n, 1'b0, "released during trip");
		pulse();
		chk(prog_busy, 1'b0, "write taken in reset");
		supply_trip = 1'b0;
		oe(1'b1, 45, 20);
		kick_en = 1'b1;
		cyc(10);
		foreach (rows[i]) begin
			write_lock = rows[i].lock;
			cyc(4);
			chk(write_allow, ~rows[i].lock, "write gate");
			pulse();
			cyc(1);
			chk(prog_busy, rows[i].busy, "write start");
			chk(bus_enable, ~rows[i].busy, "bus in write");
			cyc(PROG + 1);
			chk(prog_busy, 1'b0, "write too long");
		end
		// Second stop while busy must not restart the cycle
		pulse();
		cyc(3);
		pulse();
		cyc(PROG - 3);
		chk(prog_busy, 1'b0, "write restarted");
		$display("Test done: writes");
		supply_trip = 1'b1;
		oe(1'b0, 0, 4);
		cyc(1);
		chk(bus_enable, 1'b0, "bus on in reset");
		supply_trip = 1'b0;
		oe(1'b1, 45, 20);
		ext_lo_n = 1'b0;
		cyc(10);
		ext_lo_n = 1'b1;
		cyc(20);
		chk(hi_oe_n, 1'b1, "glitch taken");
		for (int j = 0; j < 2; j++) begin
			ext_hi = j[0];
			ext_lo_n = j[0];
			oe(1'b0, 0, 16);
			cyc(5);
			ext_hi = 1'b0;
			ext_lo_n = 1'b1;
			oe(1'b1, 30, 50);
		end
		$display("Test done: trip and manual");
		cyc(WDOG + 100);
		chk(hi_oe_n, 1'b1, "kicked watchdog fired");
		kick_en = 1'b0;
		oe(1'b0, WDOG - 70, 80);
		oe(1'b1, 45, 20);
		oe(1'b0, WDOG - 10, 20);
		kick_en = 1'b1;
		oe(1'b1, 45, 20);
		$display("Test done: watchdog");
		// Asynchronous reset in mid-write drops everything at once
		pulse();
		chk(prog_busy, 1'b1, "write before reset");
		arst_n = 1'b0;
		cyc(2);
		chk(prog_busy, 1'b0, "busy through reset");
		chk(bus_enable, 1'b0, "bus on in reset");
		oe(1'b0, 0, 1);
		arst_n = 1'b1;
		oe(1'b1, 45, 20);
		$display("Test done: reset");
		stop_test();
	end
endmodule
`default_nettype wire
